// >>> logic/adcstc_top.sv
// Analog input scan sequencer, range memory, trigger and result port
`timescale 1ns/1ps
module adcstc_top
	import adcstc_pkg::*;
#(
	parameter bit HIGH_GAIN = 1'b0
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	input  wire logic [4:0] i_addr,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_pacer_tick,
	input  wire logic       i_ext_trig,
	input  wire logic       i_ext_gate,
	input  wire logic       i_conv_done,
	input  wire logic [11:0] i_conv_data,
	output logic [7:0]      o_rdata,
	output logic            o_conv_start,
	output logic [3:0]      o_mux_channel,
	output logic [2:0]      o_gain_code,
	output logic            o_unipolar,
	output logic            o_differential,
	output logic            o_range_valid,
	output logic            o_timer0_clock_select,
	output logic            o_irq_req,
	output logic            o_fifo_empty,
	output logic            o_fifo_half,
	output logic            o_fifo_full
);
	// Whole state of the block
	typedef struct packed {
		logic [7:0]             ctrl;
		logic [3:0]             first;
		logic [3:0]             last;
		logic [3:0]             cur;
		logic [3:0]             conv_ch;
		adcstc_range_s [15:0]   rng;
		adcstc_result_s [15:0]  fifo;
		logic [3:0]             rd_ptr;
		logic [3:0]             wr_ptr;
		logic [4:0]             count;
		logic [7:0]             rdata;
		logic                   conv_start;
		logic                   irq;
		logic [2:0]             ext_sync;
		logic [2:0]             gate_sync;
		logic                   ext_state;
		logic                   gate_state;
		logic [3:0]             mux_ch;
		adcstc_range_s          out_rng;
		logic                   out_valid;
		logic                   empty;
		logic                   half;
		logic                   full;
	} adcstc_state_s;

	adcstc_state_s st, next_st;

	// Gain code validity per variant and polarity
	function automatic logic gain_ok(input adcstc_range_s r);
		if (!HIGH_GAIN)
			gain_ok = r.unipolar ? (r.gain[2] == 1'b0)
			                     : (r.gain <= 3'h4);
		else
			gain_ok = r.unipolar ? (r.gain[2] == 1'b0) : 1'b1;
	endfunction : gain_ok

	// Next channel past ch, skipping partners of differential evens
	function automatic logic [3:0] step_ch(input logic [3:0] ch,
			input adcstc_range_s [15:0] rng);
		logic [3:0] n;
		n = 4'(ch + 4'h1);
		if (n[0] && rng[{n[3:1], 1'b0}].diff)
			n = 4'(n + 4'h1);
		step_ch = n;
	endfunction : step_ch

	logic ext_edge;
	logic gate_open;
	logic trig;
	logic pop;
	logic push;
	adcstc_range_s cur_rng;

	always_comb begin
		next_st = st;
		next_st.conv_start = 1'b0;
		// Filtered external trigger: change once stages 2 and 3 agree
		next_st.ext_sync = {st.ext_sync[1:0], i_ext_trig};
		next_st.gate_sync = {st.gate_sync[1:0], i_ext_gate};
		ext_edge = 1'b0;
		if (st.ext_sync[2] == st.ext_sync[1]) begin
			next_st.ext_state = st.ext_sync[2];
			ext_edge = st.ext_sync[2] && !st.ext_state;
		end
		// Filtered gate level: change once stages 2 and 3 agree
		if (st.gate_sync[2] == st.gate_sync[1])
			next_st.gate_state = st.gate_sync[2];
		gate_open = !st.ctrl[CTL_GATE_BIT] || st.gate_state;
		trig = (st.ctrl[CTL_PACER_BIT] && i_pacer_tick)
		    || (st.ctrl[CTL_EXT_BIT] && ext_edge && gate_open);
		if (i_wr && i_addr == OFS_RESULT_LOW && st.ctrl[CTL_SW_BIT])
			trig = 1'b1;
		if (trig) begin
			next_st.conv_start = 1'b1;
			next_st.conv_ch = st.cur;
			next_st.cur = (st.cur == st.last) ? st.first
			                                  : step_ch(st.cur, st.rng);
		end
		// Register writes
		if (i_wr) begin
			unique case (i_addr)
				OFS_RANGE: begin
					next_st.rng[st.first].gain =
						i_wdata[RNG_GAIN_LSB +: 3];
					next_st.rng[st.first].unipolar = i_wdata[RNG_POL_BIT];
					next_st.rng[st.first].diff = i_wdata[RNG_DIFF_BIT];
				end
				OFS_SCAN_FIRST: begin
					next_st.first = i_wdata[3:0];
					next_st.cur = i_wdata[3:0];
				end
				OFS_SCAN_LAST: begin
					next_st.last = i_wdata[3:0];
					next_st.cur = st.first;
				end
				OFS_CONTROL: next_st.ctrl = {1'b0, i_wdata[6:0]};
				default: ;
			endcase
		end
		pop = i_rd && i_addr == OFS_RESULT_HIGH && st.count != 5'h00;
		push = i_conv_done && (st.count != FIFO_FULL || pop);
		if (push) begin
			next_st.fifo[st.wr_ptr].conversion_result_bits = i_conv_data;
			next_st.fifo[st.wr_ptr].channel_nibble = st.conv_ch;
			next_st.wr_ptr = 4'(st.wr_ptr + 4'h1);
		end
		if (pop)
			next_st.rd_ptr = 4'(st.rd_ptr + 4'h1);
		next_st.count = 5'(st.count + {4'h0, push} - {4'h0, pop});
		// Read data, low byte then high byte of the oldest entry
		next_st.rdata = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				OFS_RESULT_LOW: next_st.rdata =
					st.fifo[st.rd_ptr].conversion_result_bits[7:0];
				OFS_RESULT_HIGH: next_st.rdata =
					{st.fifo[st.rd_ptr].channel_nibble,
					 st.fifo[st.rd_ptr].conversion_result_bits[11:8]};
				OFS_CONTROL: next_st.rdata = st.ctrl;
				default: next_st.rdata = 8'h00;
			endcase
		end
		next_st.irq = st.ctrl[CTL_INTERRUPT_ENABLE_BIT] &&
			(st.ctrl[CTL_ISRC_BIT] ? (st.count >= FIFO_HALF)
			                       : (push || (st.irq && !pop)));
		// scan channel and its range out
		next_st.mux_ch = st.cur;
		next_st.out_rng = cur_rng;
		next_st.out_valid = gain_ok(cur_rng);
		if (!i_rst_n) begin
			next_st = '0;
			next_st.ctrl = RST_CONTROL;
			next_st.first = RST_CHANNEL;
			next_st.last = RST_CHANNEL;
			next_st.cur = RST_CHANNEL;
			for (int i = 0; i < 16; i++)
				next_st.rng[i] = RST_RANGE[4:0];
		end
		// Buffer flags registered from the next count
		next_st.empty = (next_st.count == 5'h00);
		next_st.half = (next_st.count >= FIFO_HALF);
		next_st.full = (next_st.count == FIFO_FULL);
	end

	always_ff @(posedge i_sys_clk) begin
		st <= next_st;
	end

	always_comb begin
		cur_rng = st.rng[{st.cur[3:1], 1'b0}];
		if (!st.cur[0])
			cur_rng = st.rng[st.cur];
		else if (!st.rng[{st.cur[3:1], 1'b0}].diff)
			cur_rng = st.rng[st.cur];
	end

	// Ports straight from the state registers
	assign o_rdata = st.rdata;
	assign o_conv_start = st.conv_start;
	assign o_mux_channel = st.mux_ch;
	assign o_differential = st.out_rng.diff;
	assign o_unipolar = st.out_rng.unipolar;
	assign o_range_valid = st.out_valid;
	assign o_gain_code = st.out_rng.gain;
	assign o_timer0_clock_select = st.ctrl[CTL_CLK0_BIT];
	assign o_irq_req = st.irq;
	assign o_fifo_empty = st.empty;
	assign o_fifo_half = st.half;
	assign o_fifo_full = st.full;

	// Assertions
	property p_soft_kick;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_RESULT_LOW && st.ctrl[CTL_SW_BIT])
		|=> o_conv_start;
	endproperty
	a_soft_kick: assert property (p_soft_kick)
		else $error("software kick lost");
	property p_no_kick;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(st.ctrl[2:0] == 3'h0 && !(i_wr && i_addr == OFS_CONTROL))
		|=> !o_conv_start;
	endproperty
	a_no_kick: assert property (p_no_kick)
		else $error("conversion without source");
	property p_wrap;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(trig && !i_wr && st.cur == st.last) |=> st.cur == $past(st.first);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("scan did not return to first");
	property p_skip;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		st.cur[0] && st.cur != st.first |-> !st.rng[{st.cur[3:1], 1'b0}].diff;
	endproperty
	a_skip: assert property (p_skip)
		else $error("odd partner visited");
	property p_restart;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_SCAN_FIRST) |=> st.cur == $past(i_wdata[3:0]);
	endproperty
	a_restart: assert property (p_restart)
		else $error("scan not restarted");
	property p_readback;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == OFS_CONTROL) |=> o_rdata == $past(st.ctrl);
	endproperty
	a_readback: assert property (p_readback)
		else $error("control read back wrong");
	property p_irq_off;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!st.ctrl[CTL_INTERRUPT_ENABLE_BIT] |=> !o_irq_req;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("interrupt while disabled");
	property p_range_store;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_RANGE)
		|=> st.rng[$past(st.first)].gain == $past(i_wdata[2:0]);
	endproperty
	a_range_store: assert property (p_range_store)
		else $error("range code not stored");
	property p_pacer;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(st.ctrl[CTL_PACER_BIT] && i_pacer_tick) |=> o_conv_start;
	endproperty
	a_pacer: assert property (p_pacer)
		else $error("pacer tick lost");
	property p_gate_shut;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(st.ctrl[2:0] == 3'h4 && st.ctrl[CTL_GATE_BIT] && !st.gate_state
		 && !i_wr) |=> !o_conv_start;
	endproperty
	a_gate_shut: assert property (p_gate_shut)
		else $error("external trigger through shut gate");
	c_wrap: cover property (@(posedge i_sys_clk) trig && st.cur == st.last);
	c_full: cover property (@(posedge i_sys_clk) o_fifo_full);
	c_ext: cover property (@(posedge i_sys_clk) ext_edge && gate_open);
endmodule : adcstc_top

// >>> logic/adcstc_pkg.sv
// Package: register map, fields and types of the scan and trigger control
package adcstc_pkg;
	// Byte offsets of the register port
	localparam logic [4:0] OFS_RESULT_LOW  = 5'h00;
	localparam logic [4:0] OFS_RESULT_HIGH = 5'h01;
	localparam logic [4:0] OFS_RANGE       = 5'h02;
	localparam logic [4:0] OFS_SCAN_FIRST  = 5'h04;
	localparam logic [4:0] OFS_SCAN_LAST   = 5'h05;
	localparam logic [4:0] OFS_CONTROL     = 5'h06;
	// Range byte fields
	localparam int RNG_GAIN_LSB = 0;
	localparam int RNG_POL_BIT  = 4;
	localparam int RNG_DIFF_BIT = 5;
	// Control byte fields
	localparam int CTL_SW_BIT    = 0;
	localparam int CTL_PACER_BIT = 1;
	localparam int CTL_EXT_BIT   = 2;
	localparam int CTL_GATE_BIT  = 3;
	localparam int CTL_INTERRUPT_ENABLE_BIT = 4;
	localparam int CTL_ISRC_BIT  = 5;
	localparam int CTL_CLK0_BIT  = 6;
	// Reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [3:0] RST_CHANNEL = 4'h0;
	localparam logic [5:0] RST_RANGE   = 6'h00;
	// Result buffer depth and half mark
	localparam int FIFO_DEPTH = 16;
	localparam logic [4:0] FIFO_HALF = 5'h08;
	localparam logic [4:0] FIFO_FULL = 5'h10;
	// Per-channel range code
	typedef struct packed {
		logic       diff;
		logic       unipolar;
		logic [2:0] gain;
	} adcstc_range_s;
	// Result word with its channel tag
	typedef struct packed {
		logic [3:0]  channel_nibble;
		logic [11:0] conversion_result_bits;
	} adcstc_result_s;
endpackage : adcstc_pkg

// >>> verification/adcstc_conv_model.sv
// Converter model: answers the latest start pulse after a fixed delay
`timescale 1ns/1ps
module adcstc_conv_model #(
	parameter int          DELAY = 3,
	parameter logic [11:0] FIRST = 12'h3a5
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_start,
	output logic             o_done,
	output logic [11:0]      o_data
);
	int          cnt = 0;
	logic [11:0] val = FIRST;
	initial begin
		o_done = 1'b0;
		o_data = ~FIRST;
	end
	// Count down, show one result for one cycle, scramble the bus otherwise
	always @(posedge i_sys_clk) begin
		o_done <= 1'b0;
		o_data <= ~o_data;
		if (i_start)
			cnt <= DELAY;
		else if (cnt > 0)
			cnt <= cnt - 1;
		if (!i_start && cnt == 1) begin
			o_done <= 1'b1;
			o_data <= val;
			val    <= val + 12'h001;
		end
	end
endmodule : adcstc_conv_model

// >>> verification/tb.sv
// Testbench of the scan and trigger control with a converter model
`timescale 1ns/1ps
module tb;
	import adcstc_pkg::*;
	logic        i_sys_clk = 1'b0;
	logic        i_rst_n   = 1'b0;
	logic [4:0]  i_addr    = 5'h00;
	logic        i_wr      = 1'b0;
	logic        i_rd      = 1'b0;
	logic [7:0]  i_wdata   = 8'h00;
	logic        i_conv_done;
	logic [11:0] i_conv_data;
	logic [7:0]  o_rdata;
	logic [3:0]  o_mux_channel;
	logic [2:0]  o_gain_code;
	logic        o_conv_start, o_unipolar, o_differential, o_range_valid;
	logic        o_timer0_clock_select, o_irq_req, o_fifo_empty;
	logic        o_fifo_half, o_fifo_full, hg_valid;
	logic        i_pacer_tick = 1'b0;
	logic        i_ext_trig   = 1'b0;
	logic        i_ext_gate   = 1'b0;
	logic [11:0] exp_val = 12'h3a5;
	int          n_errors = 0;
	int          n_tests  = 0;

	// Clock at 25 MHz
	always #20 i_sys_clk = ~i_sys_clk;

	adcstc_top #(.HIGH_GAIN(1'b0)) u_dut (
		.i_sys_clk, .i_rst_n, .i_addr, .i_wr, .i_rd, .i_wdata,
		.i_pacer_tick, .i_ext_trig, .i_ext_gate,
		.i_conv_done, .i_conv_data, .o_rdata, .o_conv_start,
		.o_mux_channel, .o_gain_code, .o_unipolar, .o_differential,
		.o_range_valid, .o_timer0_clock_select, .o_irq_req,
		.o_fifo_empty, .o_fifo_half, .o_fifo_full
	);

	// Second unit on the high-gain table, only its range flag watched
	adcstc_top #(.HIGH_GAIN(1'b1)) u_dut_hg (
		.i_sys_clk, .i_rst_n, .i_addr, .i_wr, .i_rd, .i_wdata,
		.i_pacer_tick, .i_ext_trig, .i_ext_gate,
		.i_conv_done, .i_conv_data, .o_rdata(), .o_conv_start(),
		.o_mux_channel(), .o_gain_code(), .o_unipolar(),
		.o_differential(), .o_range_valid(hg_valid),
		.o_timer0_clock_select(), .o_irq_req(), .o_fifo_empty(),
		.o_fifo_half(), .o_fifo_full()
	);

	adcstc_conv_model u_conv (
		.i_sys_clk, .i_start(o_conv_start),
		.o_done(i_conv_done), .o_data(i_conv_data)
	);

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_sys_clk) #1;
		i_wr    = 1'b1;
		i_addr  = a;
		i_wdata = d;
		@(posedge i_sys_clk) #1;
		i_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge i_sys_clk) #1;
		i_rd   = 1'b1;
		i_addr = a;
		@(posedge i_sys_clk) #1;
		i_rd = 1'b0;
		d    = o_rdata;
	endtask : rd

	// Software kick, wait for the result, check interrupt, tag and data
	task automatic conv(input logic [3:0] ch, input logic irq);
		logic [7:0] lo, hi;
		wr(OFS_RESULT_LOW, 8'h5a);
		for (int k = 0; k < 40 && o_fifo_empty !== 1'b0; k++)
			@(posedge i_sys_clk) #1;
		if (o_fifo_empty !== 1'b0) begin
			n_errors++;
			stop_test();
		end else begin
			@(posedge i_sys_clk) #1;
			chk(o_irq_req, irq);
			rd(OFS_RESULT_LOW, lo);
			rd(OFS_RESULT_HIGH, hi);
			chk({hi, lo}, {ch, exp_val});
			exp_val++;
		end
	endtask : conv

	task automatic sc_reset();
		logic [7:0] d;
		rd(OFS_CONTROL, d);
		chk(d, RST_CONTROL);
		chk(o_fifo_empty, 1'b1);
		rd(5'h03, d);
		chk(d, 8'h00);
	endtask : sc_reset

	// Wrapping scan, readback of control, push interrupt, half-mark source held low
	task automatic sc_scan();
		logic [7:0] d;
		logic [3:0] seq [7] = '{4'hd, 4'he, 4'hf, 4'h0, 4'h1, 4'h2, 4'hd};
		wr(OFS_CONTROL, 8'h71);
		rd(OFS_CONTROL, d);
		chk(d, 8'h71);
		chk(o_timer0_clock_select, 1'b1);
		wr(OFS_SCAN_FIRST, 8'hfd);
		wr(OFS_SCAN_LAST, 8'hf2);
		foreach (seq[i])
			conv(seq[i], 1'b0);
		wr(OFS_CONTROL, 8'h11);
		chk(o_timer0_clock_select, 1'b0);
		conv(4'he, 1'b1);
	endtask : sc_scan

	task automatic set_rng(input logic [3:0] ch, input logic [7:0] v,
			input logic [5:0] exp, input logic hg);
		wr(OFS_SCAN_FIRST, {4'h0, ch});
		wr(OFS_SCAN_LAST, {4'h0, ch});
		wr(OFS_RANGE, v);
		repeat (2) @(posedge i_sys_clk) #1;
		chk({o_mux_channel, o_differential, o_unipolar, o_range_valid,
			o_gain_code}, {ch, exp});
		chk(hg_valid, hg);
	endtask : set_rng

	// Range memory, gain validity and differential pair skipping
	task automatic sc_range();
		wr(OFS_CONTROL, 8'h00);
		set_rng(4'he, 8'heb, 6'h2b, 1'b1);
		set_rng(4'h0, 8'h13, 6'h1b, 1'b1);
		set_rng(4'h1, 8'h14, 6'h14, 1'b0);
		set_rng(4'h2, 8'h04, 6'h0c, 1'b1);
		set_rng(4'h3, 8'h05, 6'h05, 1'b1);
		wr(OFS_SCAN_FIRST, 8'h0e);
		wr(OFS_SCAN_LAST, 8'h01);
		repeat (2) @(posedge i_sys_clk) #1;
		chk({o_differential, o_gain_code}, 4'hb);
		wr(OFS_CONTROL, 8'h01);
		conv(4'he, 1'b0);
		conv(4'h0, 1'b0);
		conv(4'h1, 1'b0);
		conv(4'he, 1'b0);
	endtask : sc_range

	// One pulse on the trigger pin with a given control byte and gate
	task automatic ext_fire(input logic [7:0] c, input logic g,
			input logic fire);
		logic [7:0] lo, hi;
		wr(OFS_CONTROL, c);
		i_ext_gate = g;
		repeat (4) @(posedge i_sys_clk) #1;
		i_ext_trig = 1'b1;
		repeat (4) @(posedge i_sys_clk) #1;
		i_ext_trig = 1'b0;
		repeat (8) @(posedge i_sys_clk) #1;
		chk(o_fifo_empty, !fire);
		if (fire) begin
			rd(OFS_RESULT_LOW, lo);
			rd(OFS_RESULT_HIGH, hi);
			chk({hi, lo}, {4'h5, exp_val});
			exp_val++;
		end
	endtask : ext_fire

	// Pacer fills the buffer past full, drain in order, gated trigger
	task automatic sc_trig();
		logic [7:0] lo, hi;
		wr(OFS_SCAN_FIRST, 8'h05);
		wr(OFS_SCAN_LAST, 8'h05);
		wr(OFS_CONTROL, 8'h32);
		for (int i = 0; i < 17; i++) begin
			@(posedge i_sys_clk) #1;
			i_pacer_tick = 1'b1;
			@(posedge i_sys_clk) #1;
			i_pacer_tick = 1'b0;
			repeat (7) @(posedge i_sys_clk) #1;
			chk({o_fifo_full, o_fifo_half, o_irq_req},
				{i >= 15, i >= 7, i >= 7});
		end
		for (int i = 0; i < 16; i++) begin
			rd(OFS_RESULT_LOW, lo);
			rd(OFS_RESULT_HIGH, hi);
			chk({hi, lo}, {4'h5, exp_val});
			exp_val++;
		end
		// Newest result was dropped while the buffer stood full
		exp_val++;
		chk({o_fifo_empty, o_fifo_full}, 2'h2);
		ext_fire(8'h0c, 1'b0, 1'b0);
		ext_fire(8'h0c, 1'b1, 1'b1);
		ext_fire(8'h04, 1'b0, 1'b1);
	endtask : sc_trig

	initial begin
		repeat (2) @(posedge i_sys_clk);
		#1;
		i_rst_n = 1'b1;
		sc_reset();
		sc_scan();
		sc_range();
		sc_trig();
		// Reset again in mid-run with control and scan set
		wr(OFS_CONTROL, 8'h71);
		i_rst_n = 1'b0;
		repeat (2) @(posedge i_sys_clk) #1;
		i_rst_n = 1'b1;
		sc_reset();
		chk({o_mux_channel, o_timer0_clock_select}, 5'h00);
		stop_test();
	end
endmodule : tb
